// ---- verilog/cmbp_defines.vh ----
/*
 holds the constants of the byte merge and parity block.
 assumes it is included once per design file by bare name.
*/
`ifndef CMBP_DEFINES_VH
`define CMBP_DEFINES_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define CMBP_DATA_W 32
`define CMBP_BYTES 4
`define CMBP_BYTE_W 8
// ----------------------------------------
// reset values
// ----------------------------------------
`define CMBP_DATA_RST 32'h00000000
`define CMBP_FLAG_RST 1'b0
`endif

// ---- verilog/cmbp_byte_merge_parity.v ----
/*
 data register byte merge and odd parity tree of a core memory unit.
 assumes delay line taps arrive as single-cycle pulses on core_clk_i,
 produced by the memory timing logic on the same clock.
*/
`include "cmbp_defines.vh"
module cmbp_byte_merge_parity
(
  input wire core_clk_i, // 40 MHz clock
  input wire reset_i, // async reset, active high
  input wire cycle_start_i, // new memory cycle pulse
  input wire read_tap_020_i, // register clear tap
  input wire read_tap_220_i, // core data transfer tap
  input wire read_tap_300_i, // full write parity tap
  input wire read_tap_460_i, // parity check start tap
  input wire read_tap_480_i, // partial byte clear tap
  input wire read_tap_500_i, // parity check end tap
  input wire read_tap_560_i, // partial insert tap
  input wire full_port_tap_i, // full write port gating tap
  input wire write_tap_early_i, // early write tap of partial write
  input wire [3:0] byte_present_flag_i, // byte0..byte3 presence
  input wire [31:0] port_data_i, // port bus data
  input wire [31:0] core_data_i, // sense amplifier data
  input wire core_parity_i, // sensed parity bit
  input wire [2:0] address_bits_i, // address bits 22, 23, 25
  input wire fault_clear_i, // system, i/o reset or read direct
  output reg [31:0] data_reg_o, // data register bits
  output reg parity_latch_o, // parity latch
  output reg parity_good_flag_o, // word held odd ones
  output reg parity_error_flag_o, // word held even ones
  output reg parity_check_strobe_o, // check window
  output reg write_line_fire_o, // starts write delay line
  output reg fault_indicator_o, // module fault lamp
  output reg [1:0] drive_polarity_o, // x and y current direction
  output reg read_mode_o, // no bytes present
  output reg full_write_mode_o, // all bytes present
  output reg partial_write_mode_o // mixed presence
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire read_dec;
  wire full_dec;
  wire part_dec;
  assign read_dec = (byte_present_flag_i == 4'h0);
  assign full_dec = (byte_present_flag_i == 4'hf);
  assign part_dec = ~(read_dec | full_dec);

  // ----------------------------------------
  // parity tree
  // ----------------------------------------
  // first level, odd term per three bits
  wire [9:0] first_level_term;
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1)
    begin : g_first
      assign first_level_term[g] = ^data_reg_o[3*g +: 3];
    end
  endgenerate
  wire first_level_term_pair;
  assign first_level_term_pair = ~(data_reg_o[30] ^ data_reg_o[31]);
  wire first_level_term_last_triplet;
  assign first_level_term_last_triplet = first_level_term[9];
  wire [2:0] second_level_term;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_second
      assign second_level_term[g] = ^first_level_term[3*g +: 3];
    end
  endgenerate
  // last stage: triplet and pair only, true when five bits odd
  wire second_level_last_term;
  assign second_level_last_term = ~(first_level_term_last_triplet ^ first_level_term_pair);
  // third level over the lower 27 bits
  wire third_level_term;
  assign third_level_term = ^second_level_term;
  wire data_odd;
  assign data_odd = third_level_term ^ second_level_last_term;
  // fourth level, true when all 33 bits even
  wire fourth_level_term;
  assign fourth_level_term = ~(data_odd ^ parity_latch_o);

  // ----------------------------------------
  // data register and parity latch
  // ----------------------------------------
  reg [31:0] next_data;
  reg next_parity;
  integer b;
  always @*
  begin
    next_data = data_reg_o;
    next_parity = parity_latch_o;
    if (read_tap_020_i)
    begin
      next_data = `CMBP_DATA_RST;
      next_parity = 1'b0;
    end
    else
    begin
      // core word and parity share byte-3 gate, not on full write
      if (read_tap_220_i && !full_dec)
      begin
        next_data = core_data_i;
        next_parity = core_parity_i;
      end
      if (full_port_tap_i && full_dec)
        next_data = port_data_i;
      for (b = 0; b < `CMBP_BYTES; b = b + 1)
      begin
        if (read_tap_480_i && part_dec && byte_present_flag_i[b])
          next_data[b*`CMBP_BYTE_W +: `CMBP_BYTE_W] = 8'h00;
        if (read_tap_560_i && part_dec && byte_present_flag_i[b])
          next_data[b*`CMBP_BYTE_W +: `CMBP_BYTE_W] = port_data_i[b*`CMBP_BYTE_W +: `CMBP_BYTE_W];
      end
      // partial write releases parity from 560 onward
      if (read_tap_560_i && part_dec)
        next_parity = 1'b0;
      // generated parity when storing new data
      if ((read_tap_300_i && full_dec) || (write_tap_early_i && part_dec))
        next_parity = ~data_odd;
    end
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      data_reg_o <= `CMBP_DATA_RST;
      parity_latch_o <= `CMBP_FLAG_RST;
    end
    else
    begin
      data_reg_o <= next_data;
      parity_latch_o <= next_parity;
    end
  end

  // ----------------------------------------
  // check window and result flags
  // ----------------------------------------
  // strobe is registered, so flags land one cycle after it opens
  reg next_strobe;
  always @*
  begin
    next_strobe = parity_check_strobe_o;
    if (read_tap_500_i || cycle_start_i)
      next_strobe = 1'b0;
    // open at 460 unless full write
    else if (read_tap_460_i && !full_dec)
      next_strobe = 1'b1;
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      parity_check_strobe_o <= `CMBP_FLAG_RST;
      parity_good_flag_o <= `CMBP_FLAG_RST;
      parity_error_flag_o <= `CMBP_FLAG_RST;
      fault_indicator_o <= `CMBP_FLAG_RST;
      write_line_fire_o <= `CMBP_FLAG_RST;
      drive_polarity_o <= 2'h0;
      read_mode_o <= `CMBP_FLAG_RST;
      full_write_mode_o <= `CMBP_FLAG_RST;
      partial_write_mode_o <= `CMBP_FLAG_RST;
    end
    else
    begin
      parity_check_strobe_o <= next_strobe;
      // results latched while strobe open, held until cycle start clears them
      if (parity_check_strobe_o)
      begin
        parity_good_flag_o <= ~fourth_level_term;
        parity_error_flag_o <= fourth_level_term;
      end
      else if (cycle_start_i)
      begin
        parity_good_flag_o <= 1'b0;
        parity_error_flag_o <= 1'b0;
      end
      if (parity_check_strobe_o && fourth_level_term)
        fault_indicator_o <= 1'b1;
      else if (fault_clear_i)
        fault_indicator_o <= 1'b0;
      write_line_fire_o <= read_tap_560_i && part_dec;
      // x from bits 23 xor 25, y from 22 xor 25
      drive_polarity_o <= {address_bits_i[1] ^ address_bits_i[2],
                           address_bits_i[0] ^ address_bits_i[2]};
      read_mode_o <= read_dec;
      full_write_mode_o <= full_dec;
      partial_write_mode_o <= part_dec;
    end
  end
endmodule // cmbp_byte_merge_parity

// ---- bench/cmbp_port_model.sv ----
/* port requester model: byte presence flags and port bus.
 assumes the bench raises req_i for the whole of each write. */
module cmbp_port_model (
  input wire logic core_clk_i, // memory clock
  input wire logic req_i, // write request held
  input wire logic [3:0] flags_i, // bytes to write
  input wire logic [31:0] data_i, // new port bytes
  output logic [3:0] byte_present_flag_o = 4'h0, // presence to block
  output logic [31:0] port_data_o = 32'h0 // port bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus inverts its own value every cycle, so stale data returns on alternate cycles
  always @(posedge core_clk_i)
  begin
    byte_present_flag_o <= req_i ? flags_i : 4'h0;
    port_data_o <= req_i ? data_i : ~port_data_o;
  end
endmodule // cmbp_port_model

// ---- bench/cmbp_chk_sva.sv ----
/* port checker of the byte merge and parity block.
 assumes the timing taps never coincide with one another. */
module cmbp_chk (
  input wire core_clk_i, reset_i, cycle_start_i, core_parity_i, fault_indicator_o,
  input wire read_tap_220_i, read_tap_300_i, read_tap_460_i, read_tap_480_i,
  input wire read_tap_560_i, write_tap_early_i, write_line_fire_o, parity_latch_o,
  input wire [3:0] byte_present_flag_i,
  input wire [31:0] port_data_i, core_data_i, data_reg_o,
  input wire parity_good_flag_o, parity_error_flag_o, parity_check_strobe_o,
  input wire read_mode_o, full_write_mode_o, partial_write_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] f = byte_present_flag_i;
  wire [31:0] m = {{8{f[3]}}, {8{f[2]}}, {8{f[1]}}, {8{f[0]}}};
  wire [32:0] w = {parity_latch_o, data_reg_o};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_read_load: assert property (read_tap_220_i && read_mode_o |=>
    parity_latch_o == $past(core_parity_i) && data_reg_o == $past(core_data_i)) else $error("load");
  a_flag_parity: assert property ($past(parity_check_strobe_o) |->
    {parity_good_flag_o, parity_error_flag_o} == {^$past(w), ~^$past(w)}) else $error("flags");
  a_strobe_rise: assert property ($rose(parity_check_strobe_o) |->
    $past(read_tap_460_i) && !full_write_mode_o) else $error("strobe");
  a_byte_clear: assert property (read_tap_480_i && partial_write_mode_o |=>
    data_reg_o == ($past(data_reg_o) & ~$past(m))) else $error("clear");
  a_byte_insert: assert property (read_tap_560_i && partial_write_mode_o |=>
    data_reg_o == ($past(data_reg_o) & ~$past(m) | $past(port_data_i) & $past(m))
    && write_line_fire_o) else $error("insert");
  a_parity_gen: assert property (read_tap_300_i && full_write_mode_o ||
    write_tap_early_i && partial_write_mode_o |=> parity_latch_o == ~^$past(data_reg_o))
    else $error("gen");
  a_fault_lamp: assert property ($rose(parity_error_flag_o) |-> fault_indicator_o)
    else $error("fault");
  a_new_cycle: assert property (cycle_start_i && !parity_check_strobe_o |=>
    !parity_good_flag_o && !parity_error_flag_o) else $error("stale");
  c_fire: cover property (write_line_fire_o);
  c_error: cover property (parity_error_flag_o);
  c_full: cover property (read_tap_300_i && full_write_mode_o);
endmodule // cmbp_chk
bind cmbp_byte_merge_parity cmbp_chk u_cmbp_chk (.*);

// ---- bench/cmbp_byte_merge_parity_tb.sv ----
/* bench of the byte merge and parity block.
 assumes the bench plays the memory timing logic; tp bits are the taps. */
module cmbp_byte_merge_parity_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, reset_i = 1, req = 0, fc = 0, cp = 0;
  logic [9:0] tp = 0; // 020 220 300 460 480 500 560 start port early
  logic [3:0] fl = 0;
  logic [2:0] ab = 0;
  logic [31:0] pd = 0, cd = 0;
  wire [3:0] bf;
  wire [31:0] pw, dr;
  wire [1:0] dp;
  wire pl, pg, pe, ps, wf, fi, rm, fm, pm;
  int errors = 0, tests_run = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  cmbp_port_model u_cmbp_port_model (.core_clk_i, .req_i(req), .flags_i(fl), .data_i(pd),
    .byte_present_flag_o(bf), .port_data_o(pw));
  cmbp_byte_merge_parity u_cmbp_byte_merge_parity (.core_clk_i, .reset_i, .cycle_start_i(tp[7]),
    .read_tap_020_i(tp[0]), .read_tap_220_i(tp[1]), .read_tap_300_i(tp[2]),
    .read_tap_460_i(tp[3]), .read_tap_480_i(tp[4]), .read_tap_500_i(tp[5]),
    .read_tap_560_i(tp[6]), .full_port_tap_i(tp[8]), .write_tap_early_i(tp[9]),
    .byte_present_flag_i(bf), .port_data_i(pw), .core_data_i(cd), .core_parity_i(cp),
    .address_bits_i(ab), .fault_clear_i(fc), .data_reg_o(dr), .parity_latch_o(pl),
    .parity_good_flag_o(pg), .parity_error_flag_o(pe), .parity_check_strobe_o(ps),
    .write_line_fire_o(wf), .fault_indicator_o(fi), .drive_polarity_o(dp),
    .read_mode_o(rm), .full_write_mode_o(fm), .partial_write_mode_o(pm));
  task chk(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task p(input int k);
    @(posedge core_clk_i);
    tp <= 10'h1 << k;
    @(posedge core_clk_i);
    tp <= 0;
    #1;
  endtask
  task t_read(input logic [31:0] d, input logic par, input logic good);
    @(posedge core_clk_i);
    cd <= d;
    cp <= par;
    p(7);
    chk({pg, pe}, 0);
    p(0);
    chk({pl, dr}, 0);
    p(1);
    chk({rm, pl, dr}, {1'b1, par, d});
    p(3);
    @(posedge core_clk_i);
    #1;
    chk({ps, pg, pe, fi}, {1'b1, good, !good, !good});
    p(5);
    chk({ps, pg}, {1'b0, good});
    $display("read test done");
  endtask
  task t_clear;
    p(7);
    @(posedge core_clk_i);
    fc <= 1;
    @(posedge core_clk_i);
    fc <= 0;
    #1;
    chk(fi, 0);
    $display("fault clear test done");
  endtask
  task t_part;
    @(posedge core_clk_i);
    req <= 1;
    fl <= 4'h5;
    pd <= 32'haabbccdd;
    cd <= 32'h11223344;
    cp <= ~^32'h11223344;
    p(7);
    p(0);
    p(1);
    p(3);
    @(posedge core_clk_i);
    #1;
    chk({pm, pg}, 2'b11);
    p(5);
    p(4);
    chk(dr, 32'h11003300);
    p(6);
    chk({wf, pl, dr}, {2'b10, 32'h11bb33dd});
    p(9);
    chk(pl, ~^32'h11bb33dd);
    $display("partial write test done");
  endtask
  task t_full;
    @(posedge core_clk_i);
    fl <= 4'hf;
    pd <= 32'h3;
    p(7);
    p(0);
    p(8);
    p(2);
    chk({fm, pl, dr}, {2'b11, 32'h3});
    p(3);
    chk(ps, 0);
    $display("full write test done");
  endtask
  task t_pol;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk_i);
      ab <= 3'(i);
      @(posedge core_clk_i);
      #1;
      chk(dp, {i[1] ^ i[2], i[0] ^ i[2]});
    end
    $display("polarity test done");
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 0;
    t_read(32'hc0000000, 1'b1, 1'b1);
    t_read(32'h7, 1'b0, 1'b1);
    t_read(32'h7, 1'b1, 1'b0);
    t_read(32'h80000000, 1'b1, 1'b0);
    t_clear;
    t_part;
    t_full;
    t_pol;
    stop_test;
  end
  initial
  begin
    #10us;
    errors++;
    stop_test;
  end
endmodule // cmbp_byte_merge_parity_tb
